// >>> src/ebb_cfg.svh
// constants for the external byte-lane bus controller
// assumes inclusion by ebb_pkg and ebb_bus only
`ifndef EBB_CFG_SVH
`define EBB_CFG_SVH
`define EBB_ADDR_W     20
`define EBB_DATA_W     16
`define EBB_FIFO_DEPTH 16
`define EBB_BURST_MIN  5'h02
`define EBB_BURST_MAX  5'h10
`define EBB_CLK_NS     20
`endif

// >>> src/ebb_pkg.sv
// types for the external byte-lane bus controller
// assumes ebb_cfg.svh is on the include path
`include "ebb_cfg.svh"
package ebb_pkg;
  typedef enum logic [1:0] {
    EBB_IDLE   = 2'b00,
    EBB_SETUP  = 2'b01,
    EBB_STROBE = 2'b10,
    EBB_HOLD   = 2'b11
  } ebb_state_e;
  typedef logic [`EBB_ADDR_W-1:0] ebb_addr_t;
  typedef logic [`EBB_DATA_W-1:0] ebb_data_t;
endpackage

// >>> src/ebb_bus.sv
// read-data fifo and external demultiplexed bus controller with byte lanes and burst fetch
// assumes one 50 MHz clock; bus pins come from outside and are synchronised here
// Behaviour
// - 16-bit bus single byte write drives only one lane strobe
// - 8-bit bus drives the low lane strobe on every access
// - 8-bit bus never drives the high lane strobe
// - code fetches are bursts of 2 to 16 bytes
// - 16-bit burst fetch steps address bits 3..1 per word
// - 8-bit burst fetch steps address bits 3..0 per byte
// - read and fetch data captured at bus clock rising edge
// - wait input sampled at bus clock rising edge
// - data read keeps address bits above 0 held after strobes rise
`timescale 1ns/1ps
`include "ebb_cfg.svh"

module ebb_fifo #(
  parameter int W     = `EBB_DATA_W,
  parameter int DEPTH = `EBB_FIFO_DEPTH
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_q, wr_d, rd_q, rd_d;

  assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[AW-1:0]];

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    if (in_valid && in_ready) begin
      wr_d = wr_q + (AW+1)'(1);
    end
    if (out_valid && out_ready) begin
      rd_d = rd_q + (AW+1)'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (in_valid && in_ready) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule

module ebb_bus #(
  parameter int FIFO_DEPTH = `EBB_FIFO_DEPTH
) (
  input  wire logic            ref_clk,
  input  wire logic            resetn,
  input  wire logic            bus_is_16,
  input  wire logic            req_valid,
  output logic                 req_ready,
  input  wire logic            req_write,
  input  wire logic            req_fetch,
  input  wire logic            req_word,
  input  wire logic [4:0]      req_len,
  input  wire ebb_pkg::ebb_addr_t req_addr,
  input  wire ebb_pkg::ebb_data_t req_wdata,
  output logic                 rd_valid,
  input  wire logic            rd_ready,
  output ebb_pkg::ebb_data_t   rd_data,
  output logic                 bus_clock_out,
  output ebb_pkg::ebb_addr_t   addr_out,
  output logic                 cs_n,
  output logic                 oe_n,
  output logic                 we_n,
  output logic                 low_byte_strobe_n,
  output logic                 high_byte_strobe_n,
  output ebb_pkg::ebb_data_t   data_out,
  output logic                 data_oe,
  input  wire ebb_pkg::ebb_data_t data_in,
  input  wire logic            bus_wait
);
  import ebb_pkg::*;

  ebb_state_e st_q, st_d;
  ebb_addr_t  addr_q, addr_d;
  ebb_data_t  wdata_q, wdata_d;
  logic       clk_q;
  logic       wr_q, wr_d, fetch_q, fetch_d, word_q, word_d, b16_q, b16_d;
  logic [4:0] beats_q, beats_d, bi_q, bi_d;
  logic       wait_m_q, wait_s_q;
  ebb_data_t  din_m_q, din_s_q;
  logic       tick, push, fifo_in_ready;
  logic [4:0] len_c;

  // tick marks the ref_clk edge at which bus_clock_out rises
  assign tick          = !clk_q;
  assign bus_clock_out = clk_q;
  assign req_ready     = st_q == EBB_IDLE && tick;
  // data seen at the bus clock rise ending the strobe reaches din_s_q one edge later, in time for the push at the next rise
  assign push          = st_q == EBB_HOLD && tick && !wr_q && fifo_in_ready;
  assign len_c         = req_len < `EBB_BURST_MIN ? `EBB_BURST_MIN :
                         req_len > `EBB_BURST_MAX ? `EBB_BURST_MAX : req_len;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wait_m_q <= 1'b0;
      wait_s_q <= 1'b0;
      din_m_q  <= '0;
      din_s_q  <= '0;
      clk_q    <= 1'b0;
    end else begin
      wait_m_q <= bus_wait;
      wait_s_q <= wait_m_q;
      din_m_q  <= data_in;
      din_s_q  <= din_m_q;
      clk_q    <= !clk_q;
    end
  end

  always_comb begin
    st_d    = st_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    wr_d    = wr_q;
    fetch_d = fetch_q;
    word_d  = word_q;
    b16_d   = b16_q;
    beats_d = beats_q;
    bi_d    = bi_q;
    if (tick) begin
      unique case (st_q)
        EBB_IDLE: begin
          if (req_valid) begin
            st_d    = EBB_SETUP;
            addr_d  = req_addr;
            wdata_d = req_wdata;
            wr_d    = req_write && !req_fetch;
            fetch_d = req_fetch;
            word_d  = req_word || req_fetch;
            b16_d   = bus_is_16;
            bi_d    = 5'h00;
            if (req_fetch) begin
              beats_d = bus_is_16 ? 5'((len_c + 5'h01) >> 1) : len_c;
            end else begin
              beats_d = (req_word && !bus_is_16) ? 5'h02 : 5'h01;
            end
          end
        end
        EBB_SETUP: st_d = EBB_STROBE;
        EBB_STROBE: begin
          // stay while the slave asks for wait or, on a read, the fifo has no room
          if (!wait_s_q && (wr_q || fifo_in_ready)) begin
            st_d = EBB_HOLD;
          end
        end
        EBB_HOLD: begin
          // address stepped only on leaving hold so it holds after the strobes rise
          if (bi_q + 5'h01 < beats_q) begin
            st_d = EBB_SETUP;
            bi_d = bi_q + 5'h01;
            if (b16_q) begin
              addr_d = {addr_q[19:4], addr_q[3:1] + 3'h1, addr_q[0]};
            end else begin
              addr_d = {addr_q[19:4], addr_q[3:0] + 4'h1};
            end
          end else begin
            st_d = EBB_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q    <= EBB_IDLE;
      addr_q  <= '0;
      wdata_q <= '0;
      wr_q    <= 1'b0;
      fetch_q <= 1'b0;
      word_q  <= 1'b0;
      b16_q   <= 1'b0;
      beats_q <= 5'h00;
      bi_q    <= 5'h00;
    end else begin
      st_q    <= st_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      wr_q    <= wr_d;
      fetch_q <= fetch_d;
      word_q  <= word_d;
      b16_q   <= b16_d;
      beats_q <= beats_d;
      bi_q    <= bi_d;
    end
  end

  logic strobe_on;
  assign strobe_on          = st_q == EBB_STROBE;
  assign addr_out           = addr_q;
  assign cs_n               = !(st_q == EBB_SETUP || strobe_on);
  assign oe_n               = !(strobe_on && !wr_q);
  assign we_n               = !(strobe_on && wr_q);
  // wide bus: even byte on low lane, odd byte on high lane, word on both
  assign low_byte_strobe_n  = !(strobe_on && (!b16_q || word_q || !addr_q[0]));
  assign high_byte_strobe_n = !(strobe_on && b16_q && (word_q || addr_q[0]));
  assign data_oe            = wr_q && st_q != EBB_IDLE;
  assign data_out           = !b16_q ? {8'h00, (bi_q[0] ? wdata_q[15:8] : wdata_q[7:0])} :
                              (!word_q && addr_q[0]) ? {wdata_q[7:0], 8'h00} : wdata_q;

  ebb_fifo #(.W(`EBB_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (din_s_q),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  single_byte_lane_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (strobe_on && b16_q && wr_q && !word_q) |-> (low_byte_strobe_n != high_byte_strobe_n))
    else $error("both lanes on single byte write");
  low_lane_8_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!b16_q && !cs_n && !oe_n || !b16_q && !we_n) |-> !low_byte_strobe_n)
    else $error("low lane missing on narrow bus");
  no_high_8_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !b16_q |-> high_byte_strobe_n)
    else $error("high lane on narrow bus");
  no_early_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !oe_n |-> !data_oe)
    else $error("device drives data during read");
  burst_len_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (fetch_q && st_q != EBB_IDLE) |-> (b16_q ? (beats_q >= 5'h01 && beats_q <= 5'h08)
                                             : (beats_q >= 5'h02 && beats_q <= 5'h10)))
    else $error("fetch burst length out of range");
  addr_step16_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q == EBB_SETUP && $past(st_q) == EBB_HOLD && b16_q) |->
      (addr_q[3:1] == $past(addr_q[3:1]) + 3'h1 && addr_q[19:4] == $past(addr_q[19:4])
       && addr_q[0] == $past(addr_q[0])))
    else $error("wide burst step wrong");
  addr_step8_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q == EBB_SETUP && $past(st_q) == EBB_HOLD && !b16_q) |->
      (addr_q[3:0] == $past(addr_q[3:0]) + 4'h1 && addr_q[19:4] == $past(addr_q[19:4])))
    else $error("narrow burst step wrong");
  capture_edge_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    push |-> (tick && !$past(oe_n, 2) && $past(tick, 2)))
    else $error("capture off the bus clock rise");
  wait_stall_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (strobe_on && tick && wait_s_q) |=> strobe_on [*2])
    else $error("wait not honoured");
  read_addr_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_q == EBB_HOLD && !fetch_q && !wr_q) |-> $stable(addr_q[19:1]))
    else $error("read address not held");
  even_low_lane_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (strobe_on && b16_q && !word_q) |-> (low_byte_strobe_n == addr_q[0]))
    else $error("lane does not match address parity");
endmodule

// >>> sim/ebb_mem.sv
// behavioural external memory on one chip select
// assumes the pins of ebb_bus and its 50 MHz clock
`timescale 1ns/1ps
module ebb_mem (
  input  wire logic               ref_clk,
  input  wire logic               cs_n,
  input  wire logic               oe_n,
  input  wire ebb_pkg::ebb_addr_t addr_out,
  input  wire logic               slow,
  output ebb_pkg::ebb_data_t      data_in,
  output logic                    bus_wait
);
  import ebb_pkg::*;
  ebb_data_t  last_q = '0;
  logic [3:0] wcnt_q = '0;
  logic       drv;
  ebb_data_t  val;
  assign drv = !cs_n && !oe_n;
  // low lane holds the byte at the address, high lane the odd byte
  assign val = {addr_out[7:1], 1'b1, addr_out[7:0]};
  // released bus shows the inverse of the last value
  assign data_in = drv ? val : ~last_q;
  // wait raised from select so the two-flop delay still sees it at the first strobe tick
  assign bus_wait = slow && !cs_n && wcnt_q < 4'h4;
  always @(posedge ref_clk) begin
    if (drv) last_q <= val;
    wcnt_q <= !cs_n ? wcnt_q + 4'h1 : 4'h0;
  end
endmodule

// >>> sim/testbench.sv
// self-checking bench for ebb_bus with an external memory model
// assumes ebb_pkg and ebb_bus are compiled first
`timescale 1ns/1ps
module testbench;
  import ebb_pkg::*;
  logic       ref_clk = 1'b0, resetn = 1'b0, bus_is_16 = 1'b1, slow = 1'b0, rd_ready = 1'b0;
  logic       req_valid = 1'b0, req_write = 1'b0, req_fetch = 1'b0, req_word = 1'b0;
  logic [4:0] req_len = 5'h02;
  ebb_addr_t  req_addr = '0, addr_out, ha_q;
  ebb_data_t  req_wdata = 16'h005A, rd_data, data_out, data_in, dq_q;
  logic       req_ready, rd_valid, bus_clock_out, cs_n, oe_n, we_n, data_oe, bus_wait;
  logic       low_byte_strobe_n, high_byte_strobe_n, lo_seen, hi_seen;
  logic       str_q = 1'b1, hchk_q = 1'b0, is_fetch = 1'b0;
  logic [2:0] wq_q;
  int         fail_count = 0, cmp_count = 0, ocnt = 0, herr = 0;
  ebb_addr_t  aq[$];
  wire        str = low_byte_strobe_n & high_byte_strobe_n;

  always #10 ref_clk = ~ref_clk;

  ebb_bus #(.FIFO_DEPTH(16)) dut (.ref_clk, .resetn, .bus_is_16, .req_valid, .req_ready, .req_write,
    .req_fetch, .req_word, .req_len, .req_addr, .req_wdata, .rd_valid, .rd_ready, .rd_data,
    .bus_clock_out, .addr_out, .cs_n, .oe_n, .we_n, .low_byte_strobe_n, .high_byte_strobe_n,
    .data_out, .data_oe, .data_in, .bus_wait);
  ebb_mem u_mem (.ref_clk, .cs_n, .oe_n, .addr_out, .slow, .data_in, .bus_wait);

  always @(posedge ref_clk) begin
    if (!low_byte_strobe_n) lo_seen <= 1'b1;
    if (!high_byte_strobe_n) hi_seen <= 1'b1;
    if (!oe_n) ocnt <= ocnt + 1;
    if (str_q && !str) begin
      aq.push_back(addr_out);
      dq_q <= data_out;
      wq_q <= {we_n, data_oe, bus_clock_out};
    end
    hchk_q <= !str_q && str && !is_fetch;
    ha_q <= addr_out;
    if (hchk_q && addr_out[19:1] !== ha_q[19:1]) herr <= herr + 1;
    str_q <= str;
  end

  task automatic report_and_stop;
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bail;
    fail_count++;
    report_and_stop;
  endtask
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] mem(input ebb_addr_t a);
    return {a[7:1], 1'b1, a[7:0]};
  endfunction
  task automatic issue(input logic w, f, wd, b, input logic [4:0] l, input ebb_addr_t a);
    int i;
    @(negedge ref_clk);
    lo_seen = 1'b0;
    hi_seen = 1'b0;
    ocnt = 0;
    aq.delete();
    is_fetch = f;
    {req_write, req_fetch, req_word, bus_is_16, req_len, req_addr} = {w, f, wd, b, l, a};
    req_valid = 1'b1;
    for (i = 0; i < 9 && req_ready !== 1'b1; i++) @(negedge ref_clk);
    if (i == 9) bail;
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask
  task automatic idle;
    int i;
    for (i = 0; i < 400 && !(cs_n === 1'b1 && req_ready === 1'b1); i++) @(negedge ref_clk);
    if (i == 400) bail;
  endtask
  task automatic pop(input logic [15:0] e, input logic [15:0] m);
    int i;
    @(negedge ref_clk);
    for (i = 0; i < 40 && rd_valid !== 1'b1; i++) @(negedge ref_clk);
    if (i == 40) bail;
    chk("rd_data", e & m, rd_data & m);
    rd_ready = 1'b1;
    @(negedge ref_clk);
    rd_ready = 1'b0;
  endtask

  task automatic t_write;
    for (int k = 0; k < 2; k++) begin
      issue(1, 0, 0, 1, 5'h02, 20'h00124 + k);
      idle;
      chk("low_strobe", k == 0, lo_seen);
      chk("high_strobe", k == 1, hi_seen);
      chk("lane_data", 8'h5A, k ? dq_q[15:8] : dq_q[7:0]);
      chk("write_pins", 3'b011, wq_q);
    end
  endtask
  task automatic t_rd8;
    issue(0, 0, 1, 0, 5'h02, 20'h00041);
    idle;
    chk("low_strobe", 1, lo_seen);
    chk("high_strobe", 0, hi_seen);
    chk("beat_addr", 20'h00042, aq[1]);
    chk("read_pins", 3'b101, wq_q);
    pop(mem(20'h00041), 16'h00FF);
    pop(mem(20'h00042), 16'h00FF);
    chk("addr_hold", 0, herr);
  endtask
  task automatic t_fetch8;
    issue(0, 1, 0, 0, 5'h03, 20'h0020E);
    idle;
    chk("high_strobe", 0, hi_seen);
    chk("beats", 3, aq.size());
    for (int j = 0; j < 3; j++) begin
      chk("fetch_addr", 20'h00200 | ((14 + j) & 15), aq[j]);
      pop(mem(20'h00200 | ((14 + j) & 15)), 16'h00FF);
    end
  endtask
  task automatic t_wait;
    slow = 1'b1;
    issue(0, 0, 0, 1, 5'h02, 20'h00050);
    idle;
    chk("oe_stretched", 1, ocnt > 2);
    pop(mem(20'h00050), 16'h00FF);
    slow = 1'b0;
    chk("addr_hold", 0, herr);
  endtask
  task automatic t_fill;
    issue(0, 1, 0, 1, 5'h10, 20'h00106);
    idle;
    chk("beats", 8, aq.size());
    for (int j = 0; j < 8; j++) chk("fetch_addr", 20'h00100 | ((6 + 2 * j) & 15), aq[j]);
    issue(0, 1, 0, 1, 5'h1F, 20'h00100);
    idle;
    chk("beats", 8, aq.size());
    issue(0, 0, 0, 1, 5'h02, 20'h00031);
    repeat (20) @(negedge ref_clk);
    chk("full_stall", 0, oe_n);
    for (int j = 0; j < 8; j++) pop(mem(20'h00100 | ((6 + 2 * j) & 15)), 16'hFFFF);
    for (int j = 0; j < 8; j++) pop(mem(20'h00100 | (2 * j)), 16'hFFFF);
    idle;
    pop(mem(20'h00031), 16'hFF00);
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    t_write;
    t_rd8;
    t_fetch8;
    t_wait;
    t_fill;
    report_and_stop;
  end
endmodule
